// file: hdl/lcu_serial_port.sv
// Purpose: top of the serial port: receiver, interrupt and dma requests
// Assumes: rxIn and ctsIn_b come from pins; control from local flops
// Notes:   rxRead is a one-cycle strobe that empties the receive data
`timescale 1ns/100ps
`default_nettype none
// Operation
// - eight data bits, least significant first
// - optional ninth bit: parity or marker
// - low start bit, one or two stops
// - directions independent, shared rate and format
// - 16-bit divider, doubles as interrupt timer
// - separate transmit and receive enable bits
// - parity generated and checked, even or odd
// - holding-empty flag high when register free
// - written byte moves to shifter automatically
// - data-available flag high when byte held, except data bytes in the all-address scheme without errors-only
// - receive interrupt on data and errors
// - status tells error, break or data
// - framing, parity, overrun, break flagged on kept bytes only; address-data and data-only schemes drop data bytes with a low stop
// - separate interrupts, or dma requests instead
// - receive interrupt on all or errors only
// - ninth bit takes marker control value
// - clear-to-send gates new starts when enabled
// - cts sampled before start; frames finish
// - marker bit sits in parity position
// - match scheme selects receive interrupt policy
module lcu_serial_port (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  input  wire lcu_pkg::lcu_ctrl_t   ctrl,
  input  wire logic                 txLoad,
  input  wire logic [7:0]           txData,
  input  wire logic                 rxRead,
  input  wire logic                 errClear,
  input  wire logic                 rxIn,
  input  wire logic                 ctsIn_b,
  output logic                      txOut,
  output logic [7:0]                rxData,
  output lcu_pkg::lcu_status_t      status,
  output logic                      txIrq,
  output logic                      rxIrq,
  output logic                      txDmaReq,
  output logic                      rxDmaReq,
  output logic                      timerIrq
);
  //////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic rxMeta_reg;
  logic rxSync_reg;
  logic ctsMeta_reg;
  logic ctsSync_reg;
  // both pins idle high, so the flops reset high to avoid a false start
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rxMeta_reg  <= 1'b1;
      rxSync_reg  <= 1'b1;
      ctsMeta_reg <= 1'b1;
      ctsSync_reg <= 1'b1;
    end else begin
      rxMeta_reg  <= rxIn;
      rxSync_reg  <= rxMeta_reg;
      ctsMeta_reg <= ctsIn_b;
      ctsSync_reg <= ctsMeta_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // shared rate and transmitter
  logic tick;
  logic holdEmpty;
  logic txIdle;
  logic ctsOk;
  lcu_baud_gen u_baud (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .divider   (ctrl.baudDivider),
    .timerMode (ctrl.timerMode),
    .tick      (tick),
    .timerIrq  (timerIrq)
  );
  assign ctsOk = ~ctrl.clearToSendEnable | ~ctsSync_reg;
  lcu_tx u_tx (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .tick      (tick),
    .ctrl      (ctrl),
    .txLoad    (txLoad),
    .txData    (txData),
    .ctsOk     (ctsOk),
    .txOut     (txOut),
    .holdEmpty (holdEmpty),
    .idle      (txIdle)
  );

  //////////////////////////////////////////////////////////////////////
  // receiver: runs on its own state, shares only tick and format
  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_NINTH, R_STOP, R_WAIT} lcu_rxst_t;
  lcu_rxst_t  rst_reg;
  lcu_rxst_t  rst_next;
  logic [3:0] rsub_reg;
  logic [3:0] rsub_next;
  logic [2:0] rbit_reg;
  logic [2:0] rbit_next;
  logic [7:0] rshf_reg;
  logic [7:0] rshf_next;
  logic [7:0] rdat_reg;
  logic [7:0] rdat_next;
  logic       rnin_reg;
  logic       rnin_next;
  logic       avail_reg;
  logic       avail_next;
  logic       fe_reg;
  logic       fe_next;
  logic       pe_reg;
  logic       pe_next;
  logic       ov_reg;
  logic       ov_next;
  logic       brk_reg;
  logic       brk_next;
  logic       addr_reg;
  logic       addr_next;
  logic       nf_reg;
  logic       nf_next;
  logic       match_reg;
  logic       match_next;
  logic       errIrq_reg;
  logic       errIrq_next;
  logic       frameOpen_reg;
  logic       frameOpen_next;
  logic       mid;
  logic       done;
  logic       isAddr;
  logic       accept;
  logic       irqByte;
  logic       frameErr;
  logic       parErr;
  logic       isBreak;

  assign mid = tick && (rsub_reg == lcu_pkg::MID_SAMPLE);

  always_comb begin
    rst_next  = rst_reg;
    rsub_next = rsub_reg;
    rbit_next = rbit_reg;
    rshf_next = rshf_reg;
    rnin_next = rnin_reg;
    done      = 1'b0;
    if (tick) begin
      rsub_next = rsub_reg + 4'h1;
    end
    case (rst_reg)
      R_IDLE: begin
        if (ctrl.rxEnable && !rxSync_reg && tick) begin
          rst_next  = R_START;
          rsub_next = 4'h1;
        end
      end
      R_START: begin
        if (mid) begin
          rst_next  = rxSync_reg ? R_IDLE : R_DATA;
          rbit_next = 3'h0;
        end
      end
      R_DATA: begin
        if (mid) begin
          rshf_next = {rxSync_reg, rshf_reg[7:1]};
          rbit_next = rbit_reg + 3'h1;
          if (rbit_reg == 3'h7) begin
            rst_next = (ctrl.nineBitModeEnable || ctrl.parityEnable) ? R_NINTH : R_STOP;
          end
        end
      end
      R_NINTH: begin
        if (mid) begin
          rnin_next = rxSync_reg;
          rst_next  = R_STOP;
        end
      end
      // only the first stop is checked; a second may overlap the next idle
      R_STOP: begin
        if (mid) begin
          done     = 1'b1;
          // a low stop must not be taken for the next start bit
          rst_next = rxSync_reg ? R_IDLE : R_WAIT;
        end
      end
      // after a low stop or a break, wait for the line to go high again
      R_WAIT: begin
        if (rxSync_reg) begin
          rst_next = R_IDLE;
        end
      end
      default: rst_next = R_IDLE;
    endcase
  end

  assign frameErr = done && !rxSync_reg;
  assign isBreak  = frameErr && (rshf_reg == 8'h00) && !(rnin_reg && (ctrl.nineBitModeEnable || ctrl.parityEnable));
  assign parErr   = done && ctrl.parityEnable && !ctrl.nineBitModeEnable &&
                    ((^rshf_reg) ^ rnin_reg ^ ctrl.paritySelectOdd);
  assign isAddr   = ctrl.nineBitModeEnable && rnin_reg;

  // decide whether a byte is kept and whether it interrupts
  always_comb begin
    match_next = match_reg;
    accept = 1'b1;
    irqByte = 1'b1;
    if (done && ctrl.nineBitModeEnable) begin
      case (ctrl.nineBitMatchScheme)
        lcu_pkg::MATCH_ALL_ADDR: irqByte = isAddr;
        lcu_pkg::MATCH_ADDR_DATA: begin
          if (isAddr) match_next = (rshf_reg == ctrl.nodeAddress);
          accept = isAddr ? (rshf_reg == ctrl.nodeAddress) : (match_reg && !frameErr);
          irqByte = accept;
        end
        lcu_pkg::MATCH_DATA_ONLY: begin
          if (isAddr) match_next = (rshf_reg == ctrl.nodeAddress);
          accept = !isAddr && match_reg && !frameErr;
          irqByte = accept;
        end
        default: irqByte = 1'b1;
      endcase
    end
  end

  always_comb begin
    rdat_next      = rdat_reg;
    avail_next     = avail_reg;
    fe_next        = fe_reg;
    pe_next        = pe_reg;
    ov_next        = ov_reg;
    brk_next       = brk_reg;
    addr_next      = addr_reg;
    nf_next        = nf_reg;
    errIrq_next    = errIrq_reg;
    frameOpen_next = frameOpen_reg;
    if (rxRead) begin
      avail_next = 1'b0;
    end
    if (errClear) begin
      fe_next     = 1'b0;
      pe_next     = 1'b0;
      ov_next     = 1'b0;
      brk_next    = 1'b0;
      errIrq_next = 1'b0;
    end
    // an address opens a frame even when the scheme does not store it
    if (done && isAddr) begin
      frameOpen_next = 1'b1;
    end
    // set beats clear when both land together
    if (done && accept) begin
      rdat_next  = rshf_reg;
      avail_next = avail_next | irqByte | ctrl.irqOnErrorsOnly | ~ctrl.nineBitModeEnable;
      if (avail_reg && !rxRead) begin
        ov_next = 1'b1;
      end
      fe_next   = fe_next | frameErr;
      pe_next   = pe_next | parErr;
      brk_next  = brk_next | isBreak;
      addr_next = isAddr;
      nf_next   = ctrl.nineBitModeEnable && !isAddr && frameOpen_reg;
      if (!isAddr) begin
        frameOpen_next = 1'b0;
      end
      if ((avail_reg && !rxRead) || frameErr || parErr) begin
        errIrq_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_reg       <= R_IDLE;
      rsub_reg      <= 4'h0;
      rbit_reg      <= 3'h0;
      rshf_reg      <= 8'h00;
      rnin_reg      <= 1'b0;
      rdat_reg      <= 8'h00;
      avail_reg     <= 1'b0;
      fe_reg        <= 1'b0;
      pe_reg        <= 1'b0;
      ov_reg        <= 1'b0;
      brk_reg       <= 1'b0;
      addr_reg      <= 1'b0;
      nf_reg        <= 1'b0;
      match_reg     <= 1'b0;
      errIrq_reg    <= 1'b0;
      frameOpen_reg <= 1'b0;
    end else begin
      rst_reg       <= rst_next;
      rsub_reg      <= rsub_next;
      rbit_reg      <= rbit_next;
      rshf_reg      <= rshf_next;
      rnin_reg      <= rnin_next;
      rdat_reg      <= rdat_next;
      avail_reg     <= avail_next;
      fe_reg        <= fe_next;
      pe_reg        <= pe_next;
      ov_reg        <= ov_next;
      brk_reg       <= brk_next;
      addr_reg      <= addr_next;
      nf_reg        <= nf_next;
      match_reg     <= match_next;
      errIrq_reg    <= errIrq_next;
      frameOpen_reg <= frameOpen_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs: interrupts or dma, never both
  logic rxEvent;
  logic txEvent;
  assign txEvent = ctrl.txEnable && holdEmpty;
  assign rxEvent = errIrq_reg || brk_reg || (avail_reg && !ctrl.irqOnErrorsOnly);
  assign txIrq    = txEvent && !ctrl.dmaMode;
  assign rxIrq    = rxEvent && !ctrl.dmaMode;
  assign txDmaReq = txEvent && ctrl.dmaMode;
  assign rxDmaReq = ctrl.dmaMode && avail_reg;
  assign rxData   = rdat_reg;
  always_comb begin
    status = '0;
    status.txHoldingEmptyFlag  = holdEmpty;
    status.txIdle              = txIdle;
    status.rxDataAvailableFlag = avail_reg;
    status.framingError        = fe_reg;
    status.parityError         = pe_reg;
    status.overrunError        = ov_reg;
    status.breakDetected       = brk_reg;
    status.addrReceived        = addr_reg;
    status.newFrame            = nf_reg;
  end
endmodule
`default_nettype wire

// file: hdl/lcu_pkg.sv
// Purpose: shared constants and carriers for the serial port
// Assumes: one system clock, 16 receive samples per bit
// Notes:   no register map; control and status travel as structs
package lcu_pkg;

  localparam int          DATA_BITS       = 8;
  localparam int          OVERSAMPLE      = 16;
  localparam logic [3:0]  MID_SAMPLE      = 4'h7;
  localparam logic [3:0]  LAST_SAMPLE     = 4'hF;
  localparam logic [15:0] DIV_RESET       = 16'h0000;
  localparam logic [1:0]  MATCH_ALL_ADDR  = 2'h1;
  localparam logic [1:0]  MATCH_ADDR_DATA = 2'h2;
  localparam logic [1:0]  MATCH_DATA_ONLY = 2'h3;

  typedef struct packed {
    logic        txEnable;
    logic        rxEnable;
    logic        parityEnable;
    logic        paritySelectOdd;
    logic        twoStopBits;
    logic        clearToSendEnable;
    logic        nineBitModeEnable;
    logic        nineBitTxValue;
    logic [1:0]  nineBitMatchScheme;
    logic [7:0]  nodeAddress;
    logic        irqOnErrorsOnly;
    logic        dmaMode;
    logic        timerMode;
    logic [15:0] baudDivider;
  } lcu_ctrl_t;

  typedef struct packed {
    logic        txHoldingEmptyFlag;
    logic        txIdle;
    logic        rxDataAvailableFlag;
    logic        framingError;
    logic        parityError;
    logic        overrunError;
    logic        breakDetected;
    logic        addrReceived;
    logic        newFrame;
  } lcu_status_t;

endpackage

// file: hdl/lcu_baud_gen.sv
// Purpose: shared baud divider, oversample tick and timer mode
// Assumes: divider of zero stops ticks
// Notes:   one tick every divider clocks
`timescale 1ns/100ps
`default_nettype none
module lcu_baud_gen (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [15:0] divider,
  input  wire logic        timerMode,
  output logic             tick,
  output logic             timerIrq
);
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic        tick_reg;
  logic        tick_next;

  always_comb begin
    count_next = count_reg;
    tick_next  = 1'b0;
    if (divider == 16'h0000) begin
      count_next = 16'h0000;
    end else if (count_reg <= 16'h0001) begin
      count_next = divider;
      tick_next  = 1'b1;
    end else begin
      count_next = count_reg - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= 16'h0000;
      tick_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg  <= tick_next;
    end
  end

  // timer mode reuses the same counter; serial side then idles
  assign tick     = tick_reg & ~timerMode;
  assign timerIrq = tick_reg & timerMode;
endmodule
`default_nettype wire

// file: hdl/lcu_tx.sv
// Purpose: transmit holding register, shifter and clear-to-send gate
// Assumes: tick is 16x the bit rate
// Notes:   txLoad is a one-cycle write strobe
`timescale 1ns/100ps
`default_nettype none
module lcu_tx (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             tick,
  input  wire lcu_pkg::lcu_ctrl_t ctrl,
  input  wire logic             txLoad,
  input  wire logic [7:0]       txData,
  input  wire logic             ctsOk,
  output logic                  txOut,
  output logic                  holdEmpty,
  output logic                  idle
);
  typedef enum logic [2:0] {IDLE, START, DATA, NINTH, STOP1, STOP2} lcu_txst_t;
  lcu_txst_t  st_reg, st_next;
  logic [7:0] hold_reg, hold_next, shf_reg, shf_next;
  logic       full_reg, full_next, nin_reg, nin_next, out_reg, out_next;
  logic [3:0] sub_reg, sub_next;
  logic [2:0] bit_reg, bit_next;
  logic       bitEnd;

  assign bitEnd = tick && (sub_reg == lcu_pkg::LAST_SAMPLE);

  always_comb begin
    st_next = st_reg; hold_next = hold_reg; shf_next = shf_reg;
    full_next = full_reg; nin_next = nin_reg; out_next = out_reg;
    sub_next = sub_reg; bit_next = bit_reg;
    if (tick) sub_next = sub_reg + 4'h1;
    if (txLoad) begin
      hold_next = txData;
      full_next = 1'b1;
    end
    case (st_reg)
      IDLE: begin
        out_next = 1'b1;
        // cts already synchronised one clock ahead of the start
        if (full_reg && ctrl.txEnable && ctsOk) begin
          shf_next  = hold_reg;
          full_next = txLoad;
          // ninth bit is either the marker or parity, never both
          nin_next  = ctrl.nineBitModeEnable ? ctrl.nineBitTxValue :
                      (^hold_reg) ^ ctrl.paritySelectOdd;
          st_next   = START;
          sub_next  = 4'h0;
          out_next  = 1'b0;
        end
      end
      START: if (bitEnd) begin
        st_next = DATA; bit_next = 3'h0; out_next = shf_reg[0];
      end
      DATA: if (bitEnd) begin
        shf_next = {1'b1, shf_reg[7:1]};
        bit_next = bit_reg + 3'h1;
        if (bit_reg == 3'h7) begin
          if (ctrl.nineBitModeEnable || ctrl.parityEnable) begin
            st_next = NINTH; out_next = nin_reg;
          end else begin
            st_next = STOP1; out_next = 1'b1;
          end
        end else out_next = shf_reg[1];
      end
      NINTH: if (bitEnd) begin st_next = STOP1; out_next = 1'b1; end
      STOP1: if (bitEnd) st_next = ctrl.twoStopBits ? STOP2 : IDLE;
      STOP2: if (bitEnd) st_next = IDLE;
      default: st_next = IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= IDLE; hold_reg <= 8'h00; shf_reg <= 8'h00; full_reg <= 1'b0;
      nin_reg <= 1'b0; out_reg <= 1'b1; sub_reg <= 4'h0; bit_reg <= 3'h0;
    end else begin
      st_reg <= st_next; hold_reg <= hold_next; shf_reg <= shf_next; full_reg <= full_next;
      nin_reg <= nin_next; out_reg <= out_next; sub_reg <= sub_next; bit_reg <= bit_next;
    end
  end

  assign txOut     = out_reg;
  assign holdEmpty = ~full_reg;
  assign idle      = (st_reg == IDLE);
endmodule
`default_nettype wire

// file: verification/lcu_port_sva.sv
// Purpose: port checker for the serial port top
// Assumes: one clock domain, flags are levels
// Notes:   bound below the module, sees ports only
`timescale 1ns/100ps
`default_nettype none
module lcu_port_sva (
  input wire logic                 clk_sys,
  input wire logic                 rst_b,
  input wire lcu_pkg::lcu_ctrl_t   ctrl,
  input wire logic                 txLoad,
  input wire logic                 ctsIn_b,
  input wire logic                 txOut,
  input wire lcu_pkg::lcu_status_t status,
  input wire logic                 txIrq,
  input wire logic                 rxIrq,
  input wire logic                 txDmaReq,
  input wire logic                 rxDmaReq
);
  logic errAny;
  assign errAny = status.framingError | status.parityError | status.overrunError | status.breakDetected;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  a_full_on_load: assert property (txLoad |=> !status.txHoldingEmptyFlag)
    else $error("holding flag high after load");
  a_idle_line_high: assert property (status.txIdle |-> txOut)
    else $error("line low while idle");
  a_load_starts: assert property (txLoad && status.txIdle && ctrl.txEnable && !ctrl.clearToSendEnable |-> ##2 !txOut)
    else $error("no start bit after load");
  a_tx_irq_empty: assert property (ctrl.txEnable && !ctrl.dmaMode && status.txHoldingEmptyFlag |-> txIrq)
    else $error("no transmit interrupt");
  a_tx_dma_swap: assert property (ctrl.txEnable && ctrl.dmaMode && status.txHoldingEmptyFlag |-> txDmaReq && !txIrq)
    else $error("transmit request wrong in dma mode");
  a_rx_dma_data: assert property (ctrl.rxEnable && ctrl.dmaMode |-> rxDmaReq == status.rxDataAvailableFlag)
    else $error("receive request not following data");
  a_rx_irq_err: assert property (ctrl.rxEnable && !ctrl.dmaMode && errAny |-> rxIrq)
    else $error("no receive interrupt on error");
  a_rx_irq_data: assert property (ctrl.rxEnable && !ctrl.dmaMode && !ctrl.irqOnErrorsOnly
                                  && status.rxDataAvailableFlag |-> rxIrq)
    else $error("no receive interrupt on data");
  a_err_only_quiet: assert property (ctrl.irqOnErrorsOnly && !errAny |-> !rxIrq)
    else $error("receive interrupt without error");
  // cts goes through a two-flop sync, so four high samples must block
  a_cts_holds_off: assert property ((ctrl.clearToSendEnable && ctsIn_b) [*4] ##0 status.txIdle |=> txOut)
    else $error("start while cts deasserted");
  c_tx_start: cover property ($fell(txOut));
  c_rx_data: cover property ($rose(status.rxDataAvailableFlag));
  c_frame_err: cover property (status.framingError);
endmodule
bind lcu_serial_port lcu_port_sva u_sva (.clk_sys, .rst_b, .ctrl, .txLoad, .ctsIn_b, .txOut, .status,
  .txIrq, .rxIrq, .txDmaReq, .rxDmaReq);
`default_nettype wire

// file: verification/lcu_remote_node.sv
// Purpose: remote serial node facing the port pins
// Assumes: BIT_CLKS clocks per bit, line idles high
// Notes:   capture resyncs on each start edge only
`timescale 1ns/100ps
`default_nettype none
module lcu_remote_node #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic      clk_sys,
  input  wire logic      txLine,
  input  wire logic      hasExtra,
  input  wire logic      ctsHold,
  output var logic       rxLine,
  output logic           ctsLine_b,
  output var logic [9:0] capWord,
  output var logic [7:0] capCount
);
  assign ctsLine_b = ctsHold;
  ////////////////////////////////////////
  initial begin
    rxLine = 1'h1;
    capCount = 8'h00;
    forever begin
      @(negedge txLine);
      capWord = 10'h3FF;
      repeat (BIT_CLKS / 2) @(posedge clk_sys);
      // mid-bit samples; bit 8 is the extra bit or the stop
      for (int i = 0; i < 9 + int'(hasExtra); i++) begin
        repeat (BIT_CLKS) @(posedge clk_sys);
        capWord[i] = txLine;
      end
      capCount = capCount + 8'h01;
    end
  end
  task automatic send_char(input logic [7:0] d, input logic ext, input logic useExt, input logic stopLvl);
    logic [11:0] f;
    f = useExt ? {1'h1, stopLvl, ext, d, 1'h0} : {2'h3, stopLvl, d, 1'h0};
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_sys);
      #1 rxLine = f[i];
      repeat (BIT_CLKS - 1) @(posedge clk_sys);
    end
  endtask
endmodule
`default_nettype wire

// file: verification/lcu_serial_port_tb.sv
// Purpose: directed bench for the serial port
// Assumes: divider 2, so one bit lasts 32 clocks
// Notes:   remote node drives rx and cts pins
`timescale 1ns/100ps
`default_nettype none
module lcu_serial_port_tb;
  localparam int DIV = 2;
  localparam int BIT_CLKS = 16 * DIV;
  logic                clk_sys, rst_b, txLoad, rxRead, errClear, rxIn, ctsIn_b, hasExtra, ctsHold;
  logic                txOut, txIrq, rxIrq, txDmaReq, rxDmaReq, timerIrq;
  logic [7:0]          txData, rxData, capCount;
  logic [9:0]          capWord;
  lcu_pkg::lcu_ctrl_t  ctrl;
  lcu_pkg::lcu_status_t status;
  int                  errTotal = 0;
  int                  comparisons = 0;
  lcu_serial_port u_dut (.clk_sys, .rst_b, .ctrl, .txLoad, .txData, .rxRead, .errClear, .rxIn, .ctsIn_b,
    .txOut, .rxData, .status, .txIrq, .rxIrq, .txDmaReq, .rxDmaReq, .timerIrq);
  lcu_remote_node #(.BIT_CLKS(BIT_CLKS)) u_peer (.clk_sys, .txLine(txOut), .hasExtra, .ctsHold,
    .rxLine(rxIn), .ctsLine_b(ctsIn_b), .capWord, .capCount);
  ////////////////////////////////////////
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic send_tx(input logic [7:0] d);
    for (int i = 0; i < 2000 && status.txHoldingEmptyFlag !== 1'h1; i++) tick(1);
    txData = d;
    txLoad = 1'h1;
    tick(1);
    txLoad = 1'h0;
  endtask
  task automatic wait_cap(input logic [7:0] n);
    for (int i = 0; i < 3000 && capCount !== n; i++) tick(1);
  endtask
  // read and error clear together keep the receiver drained
  task automatic clr();
    errClear = 1'h1;
    rxRead = 1'h1;
    tick(1);
    errClear = 1'h0;
    rxRead = 1'h0;
  endtask
  task automatic chk_rx(input logic avail, input logic [7:0] d);
    tick(2);
    chk(status.rxDataAvailableFlag, avail);
    if (avail) chk(rxData, d);
    if (avail) clr();
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    errTotal++;
    complete_run();
  end
  initial begin
    logic [7:0] d, n;
    logic ext;
    rst_b = 1'h0;
    {txLoad, rxRead, errClear, hasExtra, ctsHold} = 5'h00;
    txData = 8'h00;
    ctrl = '0;
    ctrl.baudDivider = 16'(DIV);
    tick(3);
    rst_b = 1'h1;
    chk({status.txHoldingEmptyFlag, txOut, txIrq}, 3'h6);
    ctrl.txEnable = 1'h1;
    tick(1);
    chk(txIrq, 1'h1);
    ctrl.dmaMode = 1'h1;
    tick(1);
    chk({txDmaReq, txIrq}, 2'h2);
    ctrl.dmaMode = 1'h0;
    for (int k = 0; k < 4; k++) begin
      d = 8'hA5 + 8'(k);
      ctrl.parityEnable = k != 0;
      ctrl.paritySelectOdd = k == 2;
      ctrl.nineBitModeEnable = k == 3;
      ctrl.nineBitTxValue = 1'h1;
      ctrl.twoStopBits = k == 3;
      ext = k == 3 || (^d ^ (k == 2));
      hasExtra = k != 0;
      send_tx(d);
      wait_cap(8'(k + 1));
      chk(capWord, {1'h1, k == 0 ? 1'h1 : ext, d});
      tick(2 * BIT_CLKS);
    end
    {ctrl.parityEnable, ctrl.nineBitModeEnable, ctrl.twoStopBits, hasExtra} = 4'h0;
    ctrl.clearToSendEnable = 1'h1;
    ctsHold = 1'h1;
    send_tx(8'h3C);
    tick(4 * BIT_CLKS);
    chk({capCount, txOut}, {8'h04, 1'h1});
    ctsHold = 1'h0;
    wait_cap(8'h05);
    chk(capWord, {2'h3, 8'h3C});
    send_tx(8'hC3);
    for (int i = 0; i < 200 && txOut !== 1'h0; i++) tick(1);
    ctsHold = 1'h1;
    wait_cap(8'h06);
    chk(capWord, {2'h3, 8'hC3});
    ctrl.clearToSendEnable = 1'h0;
    send_tx(8'h81);
    wait_cap(8'h07);
    chk(capWord, {2'h3, 8'h81});
    ctsHold = 1'h0;
    ctrl.rxEnable = 1'h1;
    ctrl.dmaMode = 1'h1;
    u_peer.send_char(8'h5A, 1'h0, 1'h0, 1'h1);
    chk_rx(1'h1, 8'h5A);
    ctrl.dmaMode = 1'h0;
    u_peer.send_char(8'h11, 1'h0, 1'h0, 1'h1);
    u_peer.send_char(8'h22, 1'h0, 1'h0, 1'h1);
    tick(2);
    chk({status.overrunError, rxIrq}, 2'h3);
    clr();
    chk(status.overrunError, 1'h0);
    u_peer.send_char(8'h66, 1'h0, 1'h0, 1'h0);
    tick(2);
    chk({status.framingError, status.breakDetected}, 2'h2);
    clr();
    u_peer.send_char(8'h00, 1'h0, 1'h0, 1'h0);
    tick(2);
    chk(status.breakDetected, 1'h1);
    clr();
    ctrl.parityEnable = 1'h1;
    u_peer.send_char(8'h01, 1'h0, 1'h1, 1'h1);
    tick(2);
    chk(status.parityError, 1'h1);
    clr();
    ctrl.irqOnErrorsOnly = 1'h1;
    u_peer.send_char(8'h01, 1'h1, 1'h1, 1'h1);
    tick(2);
    chk({status.parityError, rxIrq}, 2'h0);
    chk_rx(1'h1, 8'h01);
    {ctrl.parityEnable, ctrl.irqOnErrorsOnly} = 2'h0;
    ctrl.nineBitModeEnable = 1'h1;
    ctrl.nodeAddress = 8'h21;
    for (int s = 1; s < 4; s++) begin
      ctrl.nineBitMatchScheme = 2'(s);
      u_peer.send_char(8'h21, 1'h1, 1'h1, 1'h1);
      chk_rx(s != 3, 8'h21);
      chk(status.addrReceived, s != 3);
      u_peer.send_char(8'h77, 1'h0, 1'h1, 1'h1);
      chk_rx(s != 1, 8'h77);
      chk({status.addrReceived, status.newFrame}, 2'h1);
    end
    ctrl.nineBitMatchScheme = lcu_pkg::MATCH_ADDR_DATA;
    u_peer.send_char(8'h44, 1'h1, 1'h1, 1'h1);
    chk_rx(1'h0, 8'h44);
    u_peer.send_char(8'h77, 1'h0, 1'h1, 1'h1);
    chk_rx(1'h0, 8'h77);
    ctrl.timerMode = 1'h1;
    tick(4);
    n = 8'h00;
    for (int i = 0; i < 20; i++) begin
      tick(1);
      n = n + 8'(timerIrq);
    end
    chk(n, 8'(20 / DIV));
    complete_run();
  end
endmodule
`default_nettype wire
